// *** shared/sleep_partial_regs.vh ***
// opcodes, sequencer timing and diagnostic bit positions for the sleep/partial control
`ifndef SLEEP_PARTIAL_REGS_VH
`define SLEEP_PARTIAL_REGS_VH
`define OP_DOZE 8'h10
`define OP_WAKE 8'h11
`define OP_PARTIAL 8'h12
`define OP_NORMAL 8'h13
`define OSC_START_CYC 16'h0064
`define DCDC_START_CYC 16'h0064
`define OFFSET_CHARGE_CYC 16'h0064
`define DRAIN_CYC 16'h0064
`define BLANK_FRAMES 2'h2
`define FRAME_STEP 2'h1
`define DIAG_W 8
`define DIAG_LOAD_BIT 7
`define DIAG_FUNC_BIT 6
`define CNT_W 16
`endif

// *** core/sleep_partial_mode_control.v ***
// sleep, wake and partial/normal mode control for the display command decoder
//
// Contract
// - opcode 11h without parameters wakes device
// - wake enables converter, oscillator, panel scanning
// - wake while awake is ignored
// - only sleep command 10h returns to sleep
// - self-diagnostics run after wake command
// - any reset leaves device asleep
// - oscillator, converter, offset, two blank frames
// - blank frames leave display on/off untouched
// - opcode 12h enters partial display mode
// - partial mode limits display to window
// - only 13h leaves partial mode
// - partial command in partial mode ignored
// - any reset selects normal mode
// - opcode 13h selects normal mode
// - only partial command leaves normal mode
// - normal command in normal mode ignored
// - sleep keeps interface, memory; analog stopped
// - good load and function invert diag bits
`timescale 1ns/100ps
`include "sleep_partial_regs.vh"

// the wake sequence walks oscillator start, converter start and offset
// charge, each held for a fixed count, then waits out two blank frames
// counted on frame_start before the picture is let through.
// a sleep command during any of these phases aborts into the drain phase,
// so a host that breaks the settle waits still ends in a clean sleep.
// partial/normal is a separate bit: it is taken in every power state and
// only shows on the window output once the panel is awake.
// the settle waits after wake and before sleep are the host's duty and
// are not policed here; commands arrive at most one per cycle.
// soft_reset acts like resetn but synchronously, and also clears the
// diagnostic result; it wins over a command taken in the same cycle.
// phase counts are in clock cycles, so a faster or slower clock changes
// the analog settle times and the counts must follow it.
module sleep_partial_mode_control
(
  input wire clk,
  input wire resetn,
  input wire soft_reset,
  input wire cmd_valid,
  input wire [7:0] cmd_opcode,
  input wire frame_start,
  input wire reg_load_ok,
  input wire func_ok,
  input wire display_on,
  output reg asleep,
  output reg partial_mode,
  output reg osc_enable,
  output reg dcdc_enable,
  output reg offset_charge,
  output reg scan_enable,
  output reg blank_screen,
  output reg window_limit,
  output reg show_memory,
  output reg wake_busy,
  output reg [7:0] diag_result
);

  // phase lengths in clock cycles
  localparam [`CNT_W-1:0] OSC_CYC = `OSC_START_CYC;
  localparam [`CNT_W-1:0] DCDC_CYC = `DCDC_START_CYC;
  localparam [`CNT_W-1:0] CHG_CYC = `OFFSET_CHARGE_CYC;
  localparam [`CNT_W-1:0] DRN_CYC = `DRAIN_CYC;

  // one-hot sequencer states
  localparam [6:0] S_SLEEP = 7'h01;
  localparam [6:0] S_OSC = 7'h02;
  localparam [6:0] S_DCDC = 7'h04;
  localparam [6:0] S_CHARGE = 7'h08;
  localparam [6:0] S_BLANK = 7'h10;
  localparam [6:0] S_AWAKE = 7'h20;
  localparam [6:0] S_DRAIN = 7'h40;

  // sequencer, counter and mode registers
  reg [6:0] state_q;
  reg [6:0] state_d;
  reg [`CNT_W-1:0] cnt_q;
  reg [`CNT_W-1:0] cnt_d;
  reg [1:0] frames_q;
  reg [1:0] frames_d;
  reg partial_q;
  reg partial_d;
  reg diag_q;
  reg diag_d;
  // decoded commands and next-state flags
  wire cmd_wake;
  wire cmd_doze;
  wire cmd_part;
  wire cmd_norm;
  wire cnt_done;
  wire [6:0] state_n;
  wire partial_n;
  wire nxt_sleep;
  wire nxt_osc;
  wire nxt_charge;
  wire nxt_blank;
  wire nxt_awake;
  wire [`DIAG_W-1:0] diag_next;
  genvar b;

  // opcode decode, independent of state; each state acts only on the commands it uses
  assign cmd_wake = cmd_valid && (cmd_opcode == `OP_WAKE);
  assign cmd_doze = cmd_valid && (cmd_opcode == `OP_DOZE);
  assign cmd_part = cmd_valid && (cmd_opcode == `OP_PARTIAL);
  assign cmd_norm = cmd_valid && (cmd_opcode == `OP_NORMAL);
  assign cnt_done = (cnt_q == {`CNT_W{1'b0}});

  // power sequencer next state; the counter runs down by itself and each
  // cycle-counted phase reloads it on entry. sleep during any wake phase drains first,
  // so the panel never loses its supplies while still charged
  always @*
  begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - {{(`CNT_W-1){1'b0}}, 1'b1};
    frames_d = frames_q;
    diag_d = 1'b0;
    case (state_q)
      S_SLEEP:
      begin
        if (cmd_wake)
        begin
          state_d = S_OSC;
          cnt_d = OSC_CYC;
        end
      end
      S_OSC:
      begin
        if (cmd_doze)
        begin
          state_d = S_DRAIN;
          cnt_d = DRN_CYC;
        end
        else if (cnt_done)
        begin
          state_d = S_DCDC;
          cnt_d = DCDC_CYC;
        end
      end
      S_DCDC:
      begin
        if (cmd_doze)
        begin
          state_d = S_DRAIN;
          cnt_d = DRN_CYC;
        end
        else if (cnt_done)
        begin
          state_d = S_CHARGE;
          cnt_d = CHG_CYC;
        end
      end
      S_CHARGE:
      begin
        if (cmd_doze)
        begin
          state_d = S_DRAIN;
          cnt_d = DRN_CYC;
        end
        else if (cnt_done)
        begin
          state_d = S_BLANK;
          frames_d = `BLANK_FRAMES;
        end
      end
      S_BLANK:
      begin
        if (cmd_doze)
        begin
          state_d = S_DRAIN;
          cnt_d = DRN_CYC;
        end
        else if (frame_start)
        begin
          frames_d = frames_q - `FRAME_STEP;
          if (frames_q == `FRAME_STEP)
          begin
            state_d = S_AWAKE;
            diag_d = 1'b1;
          end
        end
      end
      S_AWAKE:
      begin
        if (cmd_doze)
        begin
          state_d = S_DRAIN;
          cnt_d = DRN_CYC;
        end
      end
      S_DRAIN:
      begin
        if (cnt_done)
          state_d = S_SLEEP;
      end
      default:
      begin
        state_d = S_SLEEP;
      end
    endcase
  end

  // partial/normal mode bit, independent of sleep
  always @*
  begin
    partial_d = partial_q;
    if (cmd_part && !partial_q)
      partial_d = 1'b1;
    else if (cmd_norm && partial_q)
      partial_d = 1'b0;
  end

  // soft reset wins over any command taken in the same cycle, so outputs
  // never show a state that the registers themselves will not hold
  assign state_n = soft_reset ? S_SLEEP : state_d;
  assign partial_n = soft_reset ? 1'b0 : partial_d;

  // next-state decode, one flag each for the sleep, osc, charge, blank and awake codes
  assign nxt_sleep = (state_n == S_SLEEP);
  assign nxt_osc = (state_n == S_OSC);
  assign nxt_charge = (state_n == S_CHARGE);
  assign nxt_blank = (state_n == S_BLANK);
  assign nxt_awake = (state_n == S_AWAKE);

  // state registers; soft reset is synchronous and matches the
  // asynchronous reset values
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= S_SLEEP;
      cnt_q <= {`CNT_W{1'b0}};
      frames_q <= 2'h0;
      partial_q <= 1'b0;
    end
    else if (soft_reset)
    begin
      state_q <= S_SLEEP;
      cnt_q <= {`CNT_W{1'b0}};
      frames_q <= 2'h0;
      partial_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      frames_q <= frames_d;
      partial_q <= partial_d;
    end
  end

  // power switches; the converter waits for the oscillator, and all of
  // them stay off in sleep
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      asleep <= 1'b1;
      osc_enable <= 1'b0;
      dcdc_enable <= 1'b0;
      offset_charge <= 1'b0;
      wake_busy <= 1'b0;
    end
    else
    begin
      asleep <= nxt_sleep;
      osc_enable <= !nxt_sleep;
      dcdc_enable <= !nxt_sleep && !nxt_osc;
      offset_charge <= nxt_charge;
      wake_busy <= !nxt_sleep && !nxt_awake;
    end
  end

  // panel scanning and picture gating; display_on is only read, never
  // stored here, so the blank frames cannot disturb it
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      partial_mode <= 1'b0;
      scan_enable <= 1'b0;
      blank_screen <= 1'b1;
      window_limit <= 1'b0;
      show_memory <= 1'b0;
    end
    else
    begin
      partial_mode <= partial_n;
      scan_enable <= nxt_blank || nxt_awake;
      blank_screen <= !nxt_awake || !display_on;
      window_limit <= partial_n && nxt_awake;
      show_memory <= nxt_awake && display_on;
    end
  end

  // next diagnostic value per bit: checked bits flip on a good check,
  // the unchecked bits read as zero
  generate
    for (b = 0; b < `DIAG_W; b = b + 1)
    begin : g_diag
      if (b == `DIAG_LOAD_BIT)
      begin : g_load
        assign diag_next[b] = diag_result[b] ^ reg_load_ok;
      end
      else if (b == `DIAG_FUNC_BIT)
      begin : g_func
        assign diag_next[b] = diag_result[b] ^ func_ok;
      end
      else
      begin : g_zero
        assign diag_next[b] = 1'b0;
      end
    end
  endgenerate

  // result register; soft reset clears it and beats a trigger
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      diag_result <= 8'h00;
    else if (soft_reset)
      diag_result <= 8'h00;
    else if (diag_q)
      diag_result <= diag_next;
  end

  // one-cycle diagnostic trigger at end of wake sequence, so the
  // check inputs are sampled once the panel is already awake
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      diag_q <= 1'b0;
    else
      diag_q <= diag_d && !soft_reset;
  end

endmodule

// *** tb/host_model.sv ***
// host model: single-byte commands with a hold-off counter
`timescale 1ns/100ps
module host_model #(parameter [7:0] GAP = 8'h14)
(
  input wire clk,
  input wire resetn,
  input wire go,
  input wire [7:0] op,
  output reg cmd_valid,
  output reg [7:0] cmd_opcode,
  output wire ready
);
  reg [7:0] hold_q;
  wire take = go && ready;
  // no new command until the wait has run out
  assign ready = hold_q == 8'h00;
  // one command per request; idle opcode keeps toggling
  always @(posedge clk or negedge resetn)
    if (!resetn)
      {cmd_valid, cmd_opcode, hold_q} <= 17'h0;
    else
    begin
      cmd_valid <= take;
      cmd_opcode <= take ? op : ~cmd_opcode;
      hold_q <= take ? GAP : hold_q - {7'h0, !ready};
    end
endmodule

// *** tb/sp_props.sv ***
// assertions on the sleep and partial mode control ports
`timescale 1ns/100ps
module sp_props
(
  input logic clk, resetn, soft_reset, cmd_valid, asleep, partial_mode, osc_enable,
  input logic offset_charge, scan_enable, blank_screen, window_limit, show_memory, wake_busy,
  input logic [7:0] cmd_opcode, diag_result
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // opcode seen only while a command is taken
  wire [7:0] c = cmd_valid ? cmd_opcode : 8'h00;
  wire s = soft_reset;
  property p_wake; asleep && c == 8'h11 && !s |=> !asleep && osc_enable && wake_busy; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_stay; !asleep && !wake_busy && c != 8'h10 && !s |=> !asleep; endproperty
  a_stay: assert property (p_stay) else $error("left wake");
  property p_rst; s |=> asleep && !partial_mode && diag_result == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_mode; (c == 8'h12 || c == 8'h13) && !s |=> partial_mode != $past(c[0]); endproperty
  a_mode: assert property (p_mode) else $error("bad mode");
  property p_hold; c != 8'h12 && c != 8'h13 && !s |=> $stable(partial_mode); endproperty
  a_hold: assert property (p_hold) else $error("mode moved");
  property p_blank;
    $fell(offset_charge) && !$past(s) && $past(c) != 8'h10 |-> scan_enable && blank_screen;
  endproperty
  a_blank: assert property (p_blank) else $error("no blank");
  property p_win; window_limit |-> partial_mode && !asleep; endproperty
  a_win: assert property (p_win) else $error("bad window");
  property p_off; asleep |-> !osc_enable && !scan_enable && !show_memory; endproperty
  a_off: assert property (p_off) else $error("awake parts");
  cover property (asleep && c == 8'h11);
  cover property (!asleep && c == 8'h12);
  cover property (!asleep && c == 8'h10);
endmodule
bind sleep_partial_mode_control sp_props props_u (.*);

// *** tb/sleep_partial_mode_control_tb.sv ***
// bench for the sleep and partial mode control
`timescale 1ns/100ps
module sleep_partial_mode_control_tb;
  reg clk = 0, resetn = 0, soft_reset = 0, go = 0, frame_start = 0, display_on = 1;
  reg [7:0] op = 8'h00, o;
  reg [31:0] rnd = 32'hADD74596;
  integer fails = 0, checks_done = 0, cyc = 0, i, fr;
  reg reg_load_ok = 1, func_ok = 1;
  wire cmd_valid, ready, asleep, partial_mode, osc_enable;
  wire dcdc_enable, offset_charge, scan_enable, blank_screen, window_limit, show_memory;
  wire wake_busy;
  wire [7:0] cmd_opcode, diag_result;
  sleep_partial_mode_control dut_u (.*);
  host_model host_u (.*);
  initial forever #5 clk = ~clk;
  // frame pulse every 64 cycles; run limit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    frame_start <= cyc % 64 == 63;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      stop_test;
    end
  end
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  // expected diagnostic result after one check
  function [7:0] exp_diag(input [7:0] prev, input l, input f);
    exp_diag = {prev[7] ^ l, prev[6] ^ f, 6'h00};
  endfunction
  task chk(input c);
    checks_done = checks_done + 1;
    if (!c)
    begin
      $display("mismatch at %0t: wrong output", $time);
      fails = fails + 1;
    end
  endtask
  // hand one opcode to the host and let it settle
  task send(input [7:0] v);
    @(posedge clk);
    while (ready !== 1'b1)
      @(posedge clk);
    go <= 1;
    op <= v;
    @(posedge clk);
    go <= 0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task stop_test;
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    resetn <= 1;
    chk(asleep === 1'b1 && partial_mode === 1'b0 && diag_result === 8'h00);
    // partial, partial again, normal, normal again while asleep
    for (i = 0; i < 4; i = i + 1)
    begin
      send(8'h12 + i[1]);
      chk(partial_mode === !i[1] && asleep === 1'b1);
    end
    send(8'h11);
    chk(asleep === 1'b0 && osc_enable === 1'b1 && wake_busy === 1'b1);
    fr = 0;
    for (i = 0; i < 1000 && wake_busy !== 1'b0; i = i + 1)
    begin
      @(posedge clk);
      fr = fr + (frame_start && scan_enable && wake_busy);
    end
    repeat (2) @(posedge clk);
    #1;
    chk(fr == 2 && scan_enable === 1'b1 && show_memory === 1'b1);
    chk(diag_result === exp_diag(8'h00, 1'b1, 1'b1));
    // random opcodes other than sleep while awake
    for (i = 0; i < 8; i = i + 1)
    begin
      rnd = xs(rnd);
      o = rnd[7:0] == 8'h10 ? 8'h11 : rnd[7:0];
      @(posedge clk);
      display_on <= rnd[8];
      send(o);
    end
    chk(asleep === 1'b0 && wake_busy === 1'b0 && blank_screen === !display_on);
    send(8'h12);
    chk(window_limit === 1'b1);
    send(8'h10);
    for (i = 0; i < 1000 && asleep !== 1'b1; i = i + 1)
      @(posedge clk);
    #1;
    chk(osc_enable === 1'b0 && scan_enable === 1'b0 && partial_mode === 1'b1);
    @(posedge clk);
    soft_reset <= 1;
    @(posedge clk);
    soft_reset <= 0;
    #1;
    chk(partial_mode === 1'b0 && diag_result === 8'h00);
    // second wake with random check results
    rnd = xs(rnd);
    o = exp_diag(8'h00, rnd[0], rnd[1]);
    @(posedge clk);
    reg_load_ok <= rnd[0];
    func_ok <= rnd[1];
    send(8'h11);
    for (i = 0; i < 1000 && wake_busy !== 1'b0; i = i + 1)
      @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
    chk(asleep === 1'b0 && diag_result === o);
    // hardware reset in mid-run
    @(posedge clk);
    resetn <= 0;
    @(posedge clk);
    resetn <= 1;
    #1;
    chk(asleep === 1'b1 && osc_enable === 1'b0 && diag_result === 8'h00);
    stop_test;
  end
endmodule
